// File: bench/scsfm_osc_model.sv
// oscillator sources: fast and slow internal, stoppable crystal
`timescale 1ns/1ps
module scsfm_osc_model #(
    parameter real SLOW_HALF_NS = 400.0,
    parameter real EXT_HALF_NS = 100.0
) (
    input wire logic ext_run,
    output logic fast_osc,
    output logic slow_osc,
    output logic ext_osc
);
    // fast internal oscillator at 8 mhz
    initial begin
        fast_osc = 1'b0;
        forever #62.5 fast_osc = ~fast_osc;
    end
    // slow oscillator sped up so sample periods stay short
    initial begin
        slow_osc = 1'b0;
        forever #SLOW_HALF_NS slow_osc = ~slow_osc;
    end
    // crystal oscillates while running, a failed one stops low
    initial begin
        ext_osc = 1'b0;
        forever #EXT_HALF_NS ext_osc = ext_run ? ~ext_osc : 1'b0;
    end
endmodule : scsfm_osc_model

// File: bench/scsfm_top_sva.sv
// assertion checker for the clock switch and fail-safe ports
`timescale 1ns/1ps
module scsfm_top_sva (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SLEEP_REQ,
    input wire logic FREQ_WR,
    input wire logic [2:0] FREQ_WDATA,
    input wire logic SELECT_WR,
    input wire logic SELECT_WDATA,
    input wire logic OSC_FAIL_IRQ_ENABLE,
    input wire logic [2:0] INTOSC_FREQ_SELECT,
    input wire logic SYSCLK_SELECT,
    input wire logic STARTUP_DONE_FLAG,
    input wire logic OSC_FAIL_FLAG,
    input wire logic OSC_FAIL_IRQ,
    input wire logic FAILSAFE_ACTIVE,
    input wire logic WATCHDOG_CLEAR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // entry into fail-safe: flag up, done down, watchdog pulse
    sequence fail_entry_s;
        OSC_FAIL_FLAG && !STARTUP_DONE_FLAG ##[0:1] WATCHDOG_CLEAR;
    endsequence
    // a software exit: sleep or a write that changes the select bit
    sequence exit_req_s;
        SLEEP_REQ || (SELECT_WR && SELECT_WDATA != SYSCLK_SELECT);
    endsequence
    a_select_reset_clear: assert property (
        $rose(NRST) |-> !SYSCLK_SELECT)
        else $error("select bit set after reset");
    a_select_write_takes: assert property (
        SELECT_WR |=> SYSCLK_SELECT == $past(SELECT_WDATA))
        else $error("select write not taken");
    a_select_auto_kept: assert property (
        !SELECT_WR |=> $stable(SYSCLK_SELECT))
        else $error("select bit moved without a write");
    a_freq_write_takes: assert property (
        FREQ_WR |=> INTOSC_FREQ_SELECT == $past(FREQ_WDATA))
        else $error("frequency write not taken");
    a_fail_entry_flags: assert property (
        $rose(FAILSAFE_ACTIVE) |-> fail_entry_s)
        else $error("fail-safe entry flags wrong");
    a_fail_flag_held: assert property (
        FAILSAFE_ACTIVE && OSC_FAIL_FLAG |=> OSC_FAIL_FLAG)
        else $error("fail flag cleared during fail-safe");
    // interrupt rises with the flag and drops one cycle after it
    a_fail_irq_follows: assert property (
        OSC_FAIL_IRQ == ((OSC_FAIL_FLAG || $past(OSC_FAIL_FLAG)) &&
        $past(OSC_FAIL_IRQ_ENABLE)))
        else $error("fail interrupt does not follow flag");
    a_failsafe_exit: assert property (
        exit_req_s |=> !FAILSAFE_ACTIVE)
        else $error("fail-safe not exited");
    a_freq_no_exit: assert property (
        FAILSAFE_ACTIVE && FREQ_WR && !SLEEP_REQ && !SELECT_WR |=>
        FAILSAFE_ACTIVE)
        else $error("frequency write left fail-safe");
endmodule : scsfm_top_sva
bind scsfm_top scsfm_top_sva chk (.*);

// File: bench/scsfm_top_tb_top.sv
// self-checking bench for the clock switch and fail-safe monitor
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module scsfm_top_tb_top;
    typedef struct {logic [2:0] fi; logic si;
        logic [2:0] fo; logic so;} scsfm_row_s;
    logic CLK, NRST, FAST_OSC, SLOW_OSC, EXT_OSC, ext_run;
    logic TWO_SPEED_ENABLE, FAILSAFE_CONFIG_ENABLE, POWERUP_TIMER_EN;
    logic POWERUP_TIMER_DONE, SLEEP_REQ, WAKE_REQ, FREQ_WR, SELECT_WR;
    logic SELECT_WDATA, FAIL_FLAG_CLR, OSC_FAIL_IRQ_ENABLE, CLOCK_OUTPUT;
    logic SYSCLK_SELECT, STARTUP_DONE_FLAG, FAST_OSC_STABLE_FLAG, ASLEEP;
    logic SLOW_OSC_STABLE_FLAG, OSC_FAIL_FLAG, OSC_FAIL_IRQ, FAILSAFE_ACTIVE;
    logic WATCHDOG_CLEAR;
    logic [2:0] OSC_MODE, FREQ_WDATA, INTOSC_FREQ_SELECT;
    int errors = 0;
    int n_compared = 0;
    int k;
    scsfm_row_s rows [6] = '{'{3'h0, 1'b0, 3'h0, 1'b0},
        '{3'h1, 1'b1, 3'h1, 1'b1},
        '{3'h2, 1'b1, 3'h2, 1'b1}, '{3'h3, 1'b0, 3'h3, 1'b0},
        '{3'h4, 1'b0, 3'h4, 1'b0}, '{3'h5, 1'b0, 3'h5, 1'b0}};
    scsfm_top #(.OST_LEN(8), .START_DLY(4)) uut (.*);
    scsfm_osc_model osc (.ext_run(ext_run), .fast_osc(FAST_OSC),
        .slow_osc(SLOW_OSC), .ext_osc(EXT_OSC));
    // 25 mhz system clock
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // step past edges so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick
    // wait on done (w=0) or fail-safe (w=1), bounded, then compare
    task automatic wait_on(input int w, input logic v, input int lim);
        int i;
        i = 0;
        while ((w ? FAILSAFE_ACTIVE : STARTUP_DONE_FLAG) !== v &&
               i < lim) begin
            tick(1);
            i++;
        end
        `CHK(w ? FAILSAFE_ACTIVE : STARTUP_DONE_FLAG, v)
    endtask : wait_on
    // count clock output changes over n cycles
    task automatic toggles(input int n);
        logic p;
        k = 0;
        p = CLOCK_OUTPUT;
        repeat (n) begin
            tick(1);
            if (CLOCK_OUTPUT !== p) k++;
            p = CLOCK_OUTPUT;
        end
    endtask : toggles
    task automatic close_out;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // watchdog, about 60000 cycles
    initial begin
        #2400000;
        errors++;
        close_out;
    end
    // main sequence
    initial begin
        {NRST, SLEEP_REQ, WAKE_REQ, FREQ_WR, SELECT_WR, SELECT_WDATA} = 6'h00;
        {FAIL_FLAG_CLR, OSC_FAIL_IRQ_ENABLE, POWERUP_TIMER_DONE} = 3'h0;
        {TWO_SPEED_ENABLE, FAILSAFE_CONFIG_ENABLE, POWERUP_TIMER_EN} = 3'h7;
        OSC_MODE = scsfm_pkg::OSC_CRYSTAL_MODE;
        FREQ_WDATA = 3'h0;
        ext_run = 1'b1;
        tick(2);
        `CHK(INTOSC_FREQ_SELECT, 3'h6)
        `CHK(SYSCLK_SELECT, 1'b0)
        `CHK(FAST_OSC_STABLE_FLAG, 1'b1)
        `CHK(SLOW_OSC_STABLE_FLAG, 1'b0)
        NRST <= 1'b1;
        toggles(20);
        `CHK(k, 0)
        POWERUP_TIMER_DONE <= 1'b1;
        toggles(15);
        `CHK(k > 0, 1'b1)
        `CHK(STARTUP_DONE_FLAG, 1'b0)
        wait_on(0, 1'b1, 500);
        foreach (rows[i]) begin
            tick(1);
            FREQ_WR <= 1'b1;
            FREQ_WDATA <= rows[i].fi;
            SELECT_WR <= 1'b1;
            SELECT_WDATA <= rows[i].si;
            tick(1);
            FREQ_WR <= 1'b0;
            SELECT_WR <= 1'b0;
            `CHK(INTOSC_FREQ_SELECT, rows[i].fo)
            `CHK(SYSCLK_SELECT, rows[i].so)
            if (rows[i].si) wait_on(0, 1'b0, 600);
            else wait_on(0, 1'b1, 600);
        end
        OSC_FAIL_IRQ_ENABLE <= 1'b1;
        k = SLOW_OSC_STABLE_FLAG;
        ext_run <= 1'b0;
        wait_on(1, 1'b1, 6000);
        tick(2);
        `CHK(OSC_FAIL_FLAG, 1'b1)
        `CHK(OSC_FAIL_IRQ, 1'b1)
        `CHK(STARTUP_DONE_FLAG, 1'b0)
        `CHK(SYSCLK_SELECT, 1'b0)
        `CHK(SLOW_OSC_STABLE_FLAG, k[0])
        toggles(30);
        `CHK(k > 0, 1'b1)
        FAIL_FLAG_CLR <= 1'b1;
        FREQ_WR <= 1'b1;
        FREQ_WDATA <= 3'h7;
        tick(1);
        FAIL_FLAG_CLR <= 1'b0;
        FREQ_WR <= 1'b0;
        tick(1);
        `CHK(OSC_FAIL_FLAG, 1'b1)
        `CHK(FAILSAFE_ACTIVE, 1'b1)
        ext_run <= 1'b1;
        SLEEP_REQ <= 1'b1;
        tick(1);
        SLEEP_REQ <= 1'b0;
        FAIL_FLAG_CLR <= 1'b1;
        tick(1);
        FAIL_FLAG_CLR <= 1'b0;
        `CHK(FAILSAFE_ACTIVE, 1'b0)
        tick(1);
        `CHK(OSC_FAIL_FLAG, 1'b0)
        // wake, then sleep again in mid-count
        WAKE_REQ <= 1'b1;
        tick(1);
        WAKE_REQ <= 1'b0;
        tick(10);
        SLEEP_REQ <= 1'b1;
        tick(1);
        SLEEP_REQ <= 1'b0;
        tick(100);
        `CHK(STARTUP_DONE_FLAG, 1'b0)
        `CHK(ASLEEP, 1'b1)
        WAKE_REQ <= 1'b1;
        tick(1);
        WAKE_REQ <= 1'b0;
        wait_on(0, 1'b1, 500);
        // second reset with a non-crystal source
        OSC_MODE <= scsfm_pkg::OSC_EXTERNAL_CLOCK_INPUT;
        NRST <= 1'b0;
        tick(2);
        NRST <= 1'b1;
        wait_on(0, 1'b1, 30);
        close_out;
    end
endmodule : scsfm_top_tb_top

// File: hw/scsfm_pkg.sv
// constants and types for the system clock switch and fail-safe monitor
//
// Notes on behaviour
// [RULE1] target oscillator off: wait 10 us before new frequency applies
// [RULE2] switch waits current fall, holds low, joins on new rising edge
// [RULE3] moves among 8 MHz..125 kHz taps need no start-up delay
// [RULE4] clock select 0 takes configured source, 1 takes internal oscillator
// [RULE5] every reset clears the clock select bit
// [RULE6] automatic switches never change the clock select bit
// [RULE7] start-up done reads 1 only while running from the external source
// [RULE8] crystal modes count 1024 external oscillations before using them
// [RULE9] sleep aborts the start-up count and keeps start-up done clear
// [RULE10] two-speed needs switchover enable, select 0 and a crystal mode (code: the monitor enable also turns it on)
// [RULE11] two-speed entered after power-on (after power-up timer) and wake-up
// [RULE12] external clock, RC and other non-crystal modes disable two-speed
// [RULE13] run internally during the count, then on internal fall set done
// [RULE14] after done, hold clock low until external falls, then switch
// [RULE15] monitor enabled by its config bit, works for all external modes
// [RULE16] monitor arms only after reset or sleep exit and count expiry
// [RULE17] failure sets fail flag; interrupt raised when its enable is set
// [RULE18] after failure run internally until the fail-safe state exits
// [RULE19] entering fail-safe clears start-up done and the watchdog only
// [RULE20] sample clock is the slow internal oscillator divided by 64
// [RULE21] latch clears on sample rise, sets on primary fall, checked on fall
// [RULE22] fail-safe exits on reset, sleep or select change, not freq change
// [RULE23] fail flag cannot be cleared while fail-safe persists
// [RULE24] frequency codes 000=31k,001=125k .. 110=4M,111=8M
package scsfm_pkg;

    // ------------------------------------------------------------------
    // frequency select field
    // ------------------------------------------------------------------
    localparam int FREQ_W = 3;
    localparam logic [2:0] FREQ_RESET = 3'h6; // 4 MHz
    localparam logic [2:0] FREQ_SLOW = 3'h0; // 31 kHz tap
    localparam logic [2:0] FREQ_FAST_MAX = 3'h7; // 8 MHz, undivided

    // ------------------------------------------------------------------
    // oscillator configuration field
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OSC_LOW_POWER_CRYSTAL = 3'h0,
        OSC_CRYSTAL_MODE = 3'h1,
        OSC_HIGH_SPEED_CRYSTAL = 3'h2,
        OSC_EXTERNAL_CLOCK_INPUT = 3'h3,
        OSC_INTERNAL_IO = 3'h4,
        OSC_INTERNAL_CLOCK_OUTPUT = 3'h5,
        OSC_RC_IO = 3'h6,
        OSC_RC_CLOCK_OUTPUT = 3'h7
    } scsfm_osc_mode_e;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_OSC_START_US = 10;
    localparam int OSC_START_CYCLES =
        (T_OSC_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 8;
    localparam int OST_COUNT = 1024;
    localparam int OST_W = 11;
    localparam int SAMPLE_DIV = 64;
    localparam int SAMPLE_W = 6;
    localparam int POST_W = 6;

    // ------------------------------------------------------------------
    // clock switch sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_DELAY = 2'b01,
        SW_FALL = 2'b10,
        SW_HOLD = 2'b11
    } scsfm_sw_state_e;

endpackage : scsfm_pkg

// File: hw/scsfm_top.sv
// system clock selection, two-speed start-up and fail-safe clock monitor
`timescale 1ns/1ps

module scsfm_top #(
    parameter int OST_LEN = scsfm_pkg::OST_COUNT,
    parameter int START_DLY = scsfm_pkg::OSC_START_CYCLES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic FAST_OSC,
    input wire logic SLOW_OSC,
    input wire logic EXT_OSC,
    input wire logic [2:0] OSC_MODE,
    input wire logic TWO_SPEED_ENABLE,
    input wire logic FAILSAFE_CONFIG_ENABLE,
    input wire logic POWERUP_TIMER_EN,
    input wire logic POWERUP_TIMER_DONE,
    input wire logic SLEEP_REQ,
    input wire logic WAKE_REQ,
    input wire logic FREQ_WR,
    input wire logic [2:0] FREQ_WDATA,
    input wire logic SELECT_WR,
    input wire logic SELECT_WDATA,
    input wire logic FAIL_FLAG_CLR,
    input wire logic OSC_FAIL_IRQ_ENABLE,
    output logic CLOCK_OUTPUT,
    output logic [2:0] INTOSC_FREQ_SELECT,
    output logic SYSCLK_SELECT,
    output logic STARTUP_DONE_FLAG,
    output logic FAST_OSC_STABLE_FLAG,
    output logic SLOW_OSC_STABLE_FLAG,
    output logic OSC_FAIL_FLAG,
    output logic OSC_FAIL_IRQ,
    output logic FAILSAFE_ACTIVE,
    output logic WATCHDOG_CLEAR,
    output logic ASLEEP
);

    // ------------------------------------------------------------------
    // pin synchronisers: fast, slow, external oscillators
    // ------------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic fast_s;
    logic slow_s;
    logic ext_s;
    logic fast_rise;
    logic slow_rise;
    logic ext_rise;
    logic ext_fall;

    // two flops, then a third stage kept only for edge detection
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            sync_c <= 3'h0;
        end else begin
            sync_a <= {EXT_OSC, SLOW_OSC, FAST_OSC};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign fast_s = sync_b[0];
    assign slow_s = sync_b[1];
    assign ext_s = sync_b[2];
    assign fast_rise = sync_b[0] & ~sync_c[0];
    assign slow_rise = sync_b[1] & ~sync_c[1];
    assign ext_rise = sync_b[2] & ~sync_c[2];
    assign ext_fall = ~sync_b[2] & sync_c[2];

    // ------------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------------
    logic crystal_cfg;
    logic ext_cfg;
    logic two_speed_on;

    // only the three crystal modes need the start-up count
    assign crystal_cfg =
        (OSC_MODE == scsfm_pkg::OSC_LOW_POWER_CRYSTAL) ||
        (OSC_MODE == scsfm_pkg::OSC_CRYSTAL_MODE) ||
        (OSC_MODE == scsfm_pkg::OSC_HIGH_SPEED_CRYSTAL); // [RULE12]
    // any mode that is not internal has a primary clock to watch
    assign ext_cfg = (OSC_MODE != scsfm_pkg::OSC_INTERNAL_IO) &&
        (OSC_MODE != scsfm_pkg::OSC_INTERNAL_CLOCK_OUTPUT); // [RULE15]
    // monitor enable forces two-speed behaviour as well
    assign two_speed_on = (TWO_SPEED_ENABLE | FAILSAFE_CONFIG_ENABLE) &&
        !SYSCLK_SELECT && crystal_cfg; // [RULE10]

    // ------------------------------------------------------------------
    // postscaler on the fast oscillator, tap picked by frequency code
    // ------------------------------------------------------------------
    logic [scsfm_pkg::POST_W-1:0] post_div;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            post_div <= '0;
        end else if (fast_rise) begin
            post_div <= post_div + 1'b1;
        end
    end

    // all taps but 000 come from the fast oscillator
    function automatic logic tap_level(input logic [2:0] sel,
                                       input logic fast,
                                       input logic slow,
                                       input logic [5:0] div);
        logic [7:0] taps;
        taps = {fast, div[0], div[1], div[2], div[3], div[4], div[5], slow};
        return taps[sel]; // [RULE24]
    endfunction : tap_level

    // ------------------------------------------------------------------
    // sleep and power-on start events
    // ------------------------------------------------------------------
    logic por_pending;
    logic start_evt;

    // power-on start waits for the power-up timer when it is enabled
    assign start_evt = (por_pending &&
        (!POWERUP_TIMER_EN || POWERUP_TIMER_DONE)) || (ASLEEP && WAKE_REQ);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            por_pending <= 1'b1;
        end else if (start_evt) begin
            por_pending <= 1'b0; // [RULE11]
        end
    end

    // sleep state; sleep wins over a wake in the same cycle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ASLEEP <= 1'b0;
        end else if (SLEEP_REQ) begin
            ASLEEP <= 1'b1;
        end else if (WAKE_REQ) begin
            ASLEEP <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // oscillator start-up timer
    // ------------------------------------------------------------------
    logic [scsfm_pkg::OST_W-1:0] ost_cnt;
    logic ost_run;
    logic ost_done;

    // counts external rising edges; sleep aborts the count
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ost_cnt <= '0;
            ost_run <= 1'b0;
            ost_done <= 1'b0;
        end else if (SLEEP_REQ) begin
            ost_run <= 1'b0; // [RULE9]
            ost_done <= 1'b0;
        end else if (start_evt) begin
            ost_cnt <= '0;
            ost_run <= crystal_cfg; // [RULE8]
            ost_done <= !crystal_cfg; // [RULE12]
        end else if (ost_run && ext_rise) begin
            if (ost_cnt == scsfm_pkg::OST_W'(OST_LEN - 1)) begin
                ost_run <= 1'b0;
                ost_done <= 1'b1; // [RULE8]
            end
            ost_cnt <= ost_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // software control bits
    // ------------------------------------------------------------------
    logic select_change;

    assign select_change = SELECT_WR && (SELECT_WDATA != SYSCLK_SELECT);

    // select bit only moves on software writes
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SYSCLK_SELECT <= 1'b0; // [RULE5]
            INTOSC_FREQ_SELECT <= scsfm_pkg::FREQ_RESET;
        end else begin
            if (SELECT_WR) begin
                SYSCLK_SELECT <= SELECT_WDATA; // [RULE6]
            end
            if (FREQ_WR) begin
                INTOSC_FREQ_SELECT <= FREQ_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // fail-safe monitor: sample clock and seen latch
    // ------------------------------------------------------------------
    logic [scsfm_pkg::SAMPLE_W-1:0] sample_div;
    logic sample_q;
    logic sample_rise;
    logic sample_fall;
    logic clock_seen_latch;
    logic monitor_armed;
    logic fail_detect;

    // slow oscillator divided by 64
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sample_div <= '0;
            sample_q <= 1'b0;
        end else begin
            if (slow_rise) begin
                sample_div <= sample_div + 1'b1; // [RULE20]
            end
            sample_q <= sample_div[scsfm_pkg::SAMPLE_W-1];
        end
    end

    assign sample_rise = sample_div[scsfm_pkg::SAMPLE_W-1] & ~sample_q;
    assign sample_fall = ~sample_div[scsfm_pkg::SAMPLE_W-1] & sample_q;

    // a primary falling edge in the same cycle as a clear still sets it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            clock_seen_latch <= 1'b0;
        end else if (ext_fall) begin
            clock_seen_latch <= 1'b1; // [RULE21]
        end else if (sample_rise) begin
            clock_seen_latch <= 1'b0; // [RULE21]
        end
    end

    // watching starts only once the start-up count has expired
    // an exit request in the detection cycle wins over the detection
    assign monitor_armed = FAILSAFE_CONFIG_ENABLE && ext_cfg &&
        !SYSCLK_SELECT && ost_done && !ASLEEP && !FAILSAFE_ACTIVE &&
        !SLEEP_REQ && !select_change; // [RULE16] [RULE22]
    assign fail_detect = monitor_armed && sample_fall &&
        !clock_seen_latch; // [RULE21]

    // fail-safe state, left only by reset, sleep or a select change
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FAILSAFE_ACTIVE <= 1'b0; // [RULE22]
            WATCHDOG_CLEAR <= 1'b0;
        end else begin
            WATCHDOG_CLEAR <= fail_detect; // [RULE19]
            if (fail_detect) begin
                FAILSAFE_ACTIVE <= 1'b1; // [RULE18]
            end else if (SLEEP_REQ || select_change) begin
                FAILSAFE_ACTIVE <= 1'b0; // [RULE22]
            end
        end
    end

    // fail flag: set wins over clear, clear refused during fail-safe
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            OSC_FAIL_FLAG <= 1'b0;
            OSC_FAIL_IRQ <= 1'b0;
        end else begin
            if (fail_detect) begin
                OSC_FAIL_FLAG <= 1'b1; // [RULE17]
            end else if (FAIL_FLAG_CLR && !FAILSAFE_ACTIVE) begin
                OSC_FAIL_FLAG <= 1'b0; // [RULE23]
            end
            OSC_FAIL_IRQ <= (OSC_FAIL_FLAG | fail_detect) &&
                OSC_FAIL_IRQ_ENABLE; // [RULE17]
        end
    end

    // ------------------------------------------------------------------
    // clock switch sequencer
    // ------------------------------------------------------------------
    scsfm_pkg::scsfm_sw_state_e sw_state;
    logic cur_ext;
    logic [2:0] cur_freq;
    logic tgt_ext;
    logic [2:0] tgt_freq;
    logic [scsfm_pkg::DLY_W-1:0] dly_cnt;
    logic want_ext;
    logic cur_lvl;
    logic cur_lvl_q;
    logic tgt_lvl;
    logic tgt_lvl_q;
    logic cur_fall;
    logic tgt_rise;
    logic need_switch;
    logic crosses;
    logic target_off;

    // external source only when configured, selected and proven stable
    assign want_ext = ext_cfg && !SYSCLK_SELECT && !FAILSAFE_ACTIVE &&
        ost_done && !ASLEEP; // [RULE4] [RULE18]
    assign need_switch = (want_ext != cur_ext) ||
        (!want_ext && INTOSC_FREQ_SELECT != cur_freq);
    assign cur_lvl = cur_ext ? ext_s :
        tap_level(cur_freq, fast_s, slow_s, post_div);
    assign tgt_lvl = tap_level(tgt_freq, fast_s, slow_s, post_div);
    assign cur_fall = cur_lvl_q & ~cur_lvl;
    assign tgt_rise = tgt_lvl & ~tgt_lvl_q;
    // moving between the fast and slow oscillator, not among fast taps
    assign crosses = (INTOSC_FREQ_SELECT == scsfm_pkg::FREQ_SLOW) !=
        (cur_freq == scsfm_pkg::FREQ_SLOW); // [RULE3]
    assign target_off = (INTOSC_FREQ_SELECT == scsfm_pkg::FREQ_SLOW) ?
        !SLOW_OSC_STABLE_FLAG : !FAST_OSC_STABLE_FLAG;

    // previous levels for edge detection of current and target clocks
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cur_lvl_q <= 1'b0;
            tgt_lvl_q <= 1'b0;
        end else begin
            cur_lvl_q <= cur_lvl;
            tgt_lvl_q <= tgt_lvl;
        end
    end

    // one switch at a time; a new request is seen after return to run
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sw_state <= scsfm_pkg::SW_RUN;
            cur_ext <= 1'b0;
            cur_freq <= scsfm_pkg::FREQ_RESET;
            tgt_ext <= 1'b0;
            tgt_freq <= scsfm_pkg::FREQ_RESET;
            dly_cnt <= '0;
        end else begin
            unique case (sw_state)
                scsfm_pkg::SW_RUN: begin
                    tgt_ext <= want_ext;
                    tgt_freq <= INTOSC_FREQ_SELECT;
                    if (need_switch) begin
                        if (cur_ext && FAILSAFE_ACTIVE) begin
                            // primary is dead: no edge to wait for
                            sw_state <= scsfm_pkg::SW_HOLD; // [RULE18]
                        end else if (!want_ext && !cur_ext && crosses &&
                                     target_off) begin
                            dly_cnt <= scsfm_pkg::DLY_W'(START_DLY - 1);
                            sw_state <= scsfm_pkg::SW_DELAY; // [RULE1]
                        end else begin
                            sw_state <= scsfm_pkg::SW_FALL; // [RULE3]
                        end
                    end
                end
                scsfm_pkg::SW_DELAY: begin
                    dly_cnt <= dly_cnt - 1'b1;
                    if (dly_cnt == '0) begin
                        sw_state <= scsfm_pkg::SW_FALL; // [RULE1]
                    end
                end
                scsfm_pkg::SW_FALL: begin
                    if (cur_fall) begin
                        sw_state <= scsfm_pkg::SW_HOLD; // [RULE2] [RULE13]
                    end
                end
                scsfm_pkg::SW_HOLD: begin
                    if (tgt_ext && ext_fall) begin
                        cur_ext <= 1'b1; // [RULE14]
                        sw_state <= scsfm_pkg::SW_RUN;
                    end else if (!tgt_ext && tgt_rise) begin
                        cur_ext <= 1'b0; // [RULE2]
                        cur_freq <= tgt_freq;
                        sw_state <= scsfm_pkg::SW_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    logic join_int;

    assign join_int = (sw_state == scsfm_pkg::SW_HOLD) && !tgt_ext &&
        tgt_rise;

    // done flag follows the source actually driving the clock
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            STARTUP_DONE_FLAG <= 1'b0;
        end else if (fail_detect || SLEEP_REQ) begin
            STARTUP_DONE_FLAG <= 1'b0; // [RULE19] [RULE9]
        end else if (sw_state == scsfm_pkg::SW_FALL && tgt_ext &&
                     cur_fall) begin
            STARTUP_DONE_FLAG <= 1'b1; // [RULE13] [RULE7]
        end else if (join_int) begin
            STARTUP_DONE_FLAG <= 1'b0; // [RULE7]
        end
    end

    // stable flags move when an internal tap is connected
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FAST_OSC_STABLE_FLAG <= 1'b1;
            SLOW_OSC_STABLE_FLAG <= 1'b0;
        end else if (join_int) begin
            FAST_OSC_STABLE_FLAG <=
                (tgt_freq != scsfm_pkg::FREQ_SLOW); // [RULE2]
            if (!cur_ext) begin
                // a fail-safe fallback leaves the slow flag alone
                SLOW_OSC_STABLE_FLAG <= (tgt_freq == scsfm_pkg::FREQ_SLOW) ||
                    FAILSAFE_CONFIG_ENABLE || POWERUP_TIMER_EN; // [RULE19]
            end
        end
    end

    // ------------------------------------------------------------------
    // clock output
    // ------------------------------------------------------------------
    logic exec_hold;

    // without two-speed, crystal start-up stalls execution entirely
    assign exec_hold = (crystal_cfg && !SYSCLK_SELECT && !ost_done &&
        !two_speed_on) || por_pending; // [RULE10] [RULE13]

    // held low while asleep, stalled, or between two sources
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CLOCK_OUTPUT <= 1'b0;
        end else begin
            CLOCK_OUTPUT <= cur_lvl && !ASLEEP && !exec_hold &&
                (sw_state != scsfm_pkg::SW_HOLD); // [RULE2] [RULE14]
        end
    end

endmodule : scsfm_top
